// >>> rtl/eezl_loader.sv
/*
 * Serial eeprom configuration loader with an apb register slave.
 * After reset, or on a software reload, it reads the header word and
 * walks flagged zones 1 to 3: power data table, local configuration bytes
 * and card information structure tuples.
 * Assumes an apb master on pclk and a serial eeprom on four pins; the
 * eeprom data pin is asynchronous to pclk.
 */
`timescale 1ns/1ns
`include "eezl_map.svh"

module eezl_loader #(
    parameter int AW        = 6,                 // eeprom address bits
    parameter int CIS_DEPTH = 32,                // tuple ram dwords
    parameter logic [31:0] CIS_DEFAULT = 32'h0000_0000 // hardwired cis
) (
    input  wire logic        pclk,      // system clock
    input  wire logic        presetn,   // async reset, active low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [11:0] paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic [31:0]      prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error / retry
    output logic             ee_sk,     // eeprom serial clock
    output logic             ee_cs,     // eeprom chip select
    output logic             ee_di,     // data to eeprom
    input  wire logic        ee_do      // data from eeprom
);
    import eezl_pkg::*;

    localparam int HALF = (`EEZL_SK_HALF_NS + `EEZL_PCLK_NS - 1)
                          / `EEZL_PCLK_NS;
    localparam int CW   = $clog2(CIS_DEPTH);
    localparam logic [31:0] CIS_END = 32'(`EEZL_OFF_CIS) + 32'(4 * CIS_DEPTH);

    eezl_ld_t          st_r;
    logic [2:0]        zone_r;
    logic [4:0]        flags_r;
    logic [AW-1:0]     eaddr_r;
    logic              z3first_r;
    logic [15:0]       tcnt_r;
    logic [15:0]       bidx_r;
    logic              busy_r;
    logic              rd_start_r;
    logic [31:0]       lcc_r;
    logic [3:0]        pm_sel_r;
    logic [9:0]        pm_tab [16];
    logic [31:0]       cis_ram [CIS_DEPTH];
    logic              do_s1_r;
    logic              do_s2_r;
    logic              rd_sk;
    logic              rd_cs;
    logic              rd_di;
    logic [15:0]       rd_data;
    logic              rd_done;
    logic              word_ev;
    logic              more;
    logic              apb_first;
    logic              apb_wr;
    logic              reload_req;
    logic              cis_hit;
    logic [CW-1:0]     cis_idx;
    logic [31:0]       rd_val;
    logic              rd_err;

    // serial word engine; pins pass through the loader when it is busy
    eezl_word_reader #(
        .AW     (AW),
        .HALF   (HALF)
    ) u_reader (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (rd_start_r),
        .addr    (eaddr_r),
        .sdi     (do_s2_r),
        .sk      (rd_sk),
        .cs      (rd_cs),
        .di      (rd_di),
        .rdata   (rd_data),
        .done    (rd_done)
    );

    assign word_ev = (st_r == LD_WAIT) && rd_done;
    assign more    = rd_data[`EEZL_CONT_BIT];

    // eeprom data pin is asynchronous: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            do_s1_r <= 1'b0;
            do_s2_r <= 1'b0;
        end else begin
            do_s1_r <= ee_do;
            do_s2_r <= do_s1_r;
        end
    end

    // loader sequence; busy from reset so the download starts at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r       <= LD_FETCH;
            zone_r     <= 3'd0;
            flags_r    <= '0;
            eaddr_r    <= '0;
            z3first_r  <= 1'b0;
            tcnt_r     <= '0;
            busy_r     <= 1'b1;
            rd_start_r <= 1'b0;
        end else begin
            rd_start_r <= 1'b0;
            case (st_r)
                LD_IDLE: begin
                    if (reload_req) begin
                        busy_r  <= 1'b1;
                        zone_r  <= 3'd0;
                        flags_r <= '0;
                        eaddr_r <= '0;
                        st_r    <= LD_FETCH;
                    end
                end
                LD_FETCH: begin
                    rd_start_r <= 1'b1;
                    st_r       <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (rd_done) begin
                        // each word consumed moves on one address
                        eaddr_r <= eaddr_r + 1'b1;
                        case (zone_r)
                            3'd0: begin
                                if (rd_data[15:8] == `EEZL_SIGNATURE) begin
                                    flags_r <= {
                                        rd_data[`EEZL_HDR_Z5],
                                        rd_data[`EEZL_HDR_Z4],
                                        rd_data[`EEZL_HDR_Z3],
                                        rd_data[`EEZL_HDR_Z2],
                                        rd_data[`EEZL_HDR_Z1]};
                                    st_r <= LD_NEXT;
                                end else begin
                                    busy_r <= 1'b0;
                                    st_r   <= LD_IDLE;
                                end
                            end
                            3'd1, 3'd2: begin
                                st_r <= more ? LD_FETCH : LD_NEXT;
                            end
                            default: begin
                                if (z3first_r) begin
                                    z3first_r <= 1'b0;
                                    tcnt_r    <= rd_data;
                                    st_r <= (rd_data == '0) ? LD_NEXT
                                                            : LD_FETCH;
                                end else if (tcnt_r <= `EEZL_TUPLE_STEP)
                                begin
                                    tcnt_r <= '0;
                                    st_r   <= LD_NEXT;
                                end else begin
                                    tcnt_r <= tcnt_r - `EEZL_TUPLE_STEP;
                                    st_r   <= LD_FETCH;
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    // lowest remaining flagged zone comes next
                    if (flags_r[0]) begin
                        flags_r[0] <= 1'b0;
                        zone_r     <= 3'd1;
                        st_r       <= LD_FETCH;
                    end else if (flags_r[1]) begin
                        flags_r[1] <= 1'b0;
                        zone_r     <= 3'd2;
                        st_r       <= LD_FETCH;
                    end else if (flags_r[2]) begin
                        flags_r[2] <= 1'b0;
                        zone_r     <= 3'd3;
                        z3first_r  <= 1'b1;
                        st_r       <= LD_FETCH;
                    end else begin
                        // zones 4 and 5 are not parsed: end here
                        busy_r <= 1'b0;
                        st_r   <= LD_IDLE;
                    end
                end
            endcase
        end
    end

    // tuple byte pointer, two bytes per data word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bidx_r <= '0;
        end else if (word_ev && zone_r == 3'd3 && z3first_r) begin
            bidx_r <= '0;
        end else if (word_ev && zone_r == 3'd3) begin
            bidx_r <= bidx_r + `EEZL_TUPLE_STEP;
        end
    end

    // power data table indexed by select value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                pm_tab[i] <= '0;
            end
        end else if (word_ev && zone_r == 3'd1) begin
            // bit 14 is reserved and dropped here
            pm_tab[rd_data[13:10]] <= rd_data[9:0];
        end
    end

    // tuple ram; words beyond the ram depth are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CIS_DEPTH; i++) begin
                cis_ram[i] <= '0;
            end
        end else if (word_ev && zone_r == 3'd3 && !z3first_r
                     && bidx_r[15:2] < 14'(CIS_DEPTH)) begin
            if (bidx_r[1]) begin
                cis_ram[bidx_r[CW+1:2]][31:16] <= rd_data;
            end else begin
                cis_ram[bidx_r[CW+1:2]][15:0] <= rd_data;
            end
        end
    end

    // local configuration control: bus writes, zone 2 and status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcc_r <= `EEZL_LCC_RST;
        end else begin
            if (apb_wr && paddr == `EEZL_OFF_LCC) begin
                // valid and reload bits are not stored from the bus
                lcc_r[27:0] <= pwdata[27:0];
            end
            if (word_ev && zone_r == 3'd2
                && rd_data[14:8] < `EEZL_Z2_LIMIT) begin
                lcc_r[8*rd_data[9:8] +: 8] <= rd_data[7:0];
            end
            if (word_ev && zone_r == 3'd0
                && rd_data[15:8] == `EEZL_SIGNATURE) begin
                lcc_r[`EEZL_LCC_VALID] <= 1'b1;
            end
            if (word_ev && zone_r == 3'd3 && z3first_r) begin
                lcc_r[`EEZL_LCC_CIS_RAM] <= 1'b1;
            end
        end
    end

    // pin drive: loader while busy, software bit-bang otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_sk <= 1'b0;
            ee_cs <= 1'b0;
            ee_di <= 1'b0;
        end else if (busy_r) begin
            ee_sk <= rd_sk;
            ee_cs <= rd_cs;
            ee_di <= rd_di;
        end else begin
            ee_sk <= lcc_r[`EEZL_LCC_PIN_CLK];
            ee_cs <= lcc_r[`EEZL_LCC_PIN_CS];
            ee_di <= lcc_r[`EEZL_LCC_PIN_DI];
        end
    end

    // apb: answer decided in the first access cycle, write committed
    // at the edge where the master sees pready
    assign apb_first  = psel && penable && !pready;
    assign apb_wr     = psel && penable && pready && pwrite && !pslverr;
    assign reload_req = apb_wr && paddr == `EEZL_OFF_LCC
                        && pwdata[`EEZL_LCC_RELOAD];
    assign cis_hit    = 32'(paddr) >= 32'(`EEZL_OFF_CIS)
                        && 32'(paddr) < CIS_END;
    assign cis_idx    = paddr[CW+1:2];

    // read mux and decode
    always_comb begin
        rd_val = '0;
        rd_err = 1'b0;
        if (busy_r) begin
            rd_err = 1'b1;
        end else if (paddr == `EEZL_OFF_LCC) begin
            rd_val = lcc_r;
            rd_val[`EEZL_LCC_PIN_DO] = do_s2_r;
            rd_val[`EEZL_LCC_RELOAD] = 1'b0;
        end else if (paddr == `EEZL_OFF_PM_SEL) begin
            rd_val[3:0] = pm_sel_r;
        end else if (paddr == `EEZL_OFF_PM_DATA) begin
            rd_val[9:0] = pm_tab[pm_sel_r];
        end else if (paddr == `EEZL_OFF_STATUS) begin
            rd_val[0]    = busy_r;
            rd_val[2:1]  = st_r;
            rd_val[5:3]  = zone_r;
            rd_val[31:16] = bidx_r;
        end else if (cis_hit) begin
            // hardwired structure until zone 3 has read its count word and set the ram bit
            rd_val = lcc_r[`EEZL_LCC_CIS_RAM] ? cis_ram[cis_idx]
                                              : CIS_DEFAULT;
        end else begin
            rd_err = 1'b1;
        end
    end

    // registered apb answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (apb_first) begin
            pready  <= 1'b1;
            pslverr <= rd_err;
            prdata  <= rd_val;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    // power data select written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_sel_r <= '0;
        end else if (apb_wr && paddr == `EEZL_OFF_PM_SEL) begin
            pm_sel_r <= pwdata[3:0];
        end
    end

endmodule

// >>> rtl/eezl_map.svh
/*
 * Address map, field positions, reset values and timing figures of the
 * serial configuration loader.
 * Assumes inclusion by bare name; the macros need nothing from eezl_pkg.
 */
`ifndef EEZL_MAP_SVH
`define EEZL_MAP_SVH

// apb byte addresses
`define EEZL_OFF_LCC      12'h000
`define EEZL_OFF_PM_SEL   12'h004
`define EEZL_OFF_PM_DATA  12'h008
`define EEZL_OFF_STATUS   12'h00C
`define EEZL_OFF_CIS      12'h100

// local_config_control layout and reset value
`define EEZL_LCC_RST      32'h0000_0000
`define EEZL_LCC_CIS_RAM  21
`define EEZL_LCC_PIN_CLK  24
`define EEZL_LCC_PIN_CS   25
`define EEZL_LCC_PIN_DI   26
`define EEZL_LCC_PIN_DO   27
`define EEZL_LCC_VALID    28
`define EEZL_LCC_RELOAD   29
// zone 2 may write byte offsets below this one only
`define EEZL_Z2_LIMIT     7'h03

// eeprom word fields
`define EEZL_SIGNATURE    8'hB5
`define EEZL_CONT_BIT     15
`define EEZL_HDR_Z1       4
`define EEZL_HDR_Z2       3
`define EEZL_HDR_Z3       2
`define EEZL_HDR_Z4       1
`define EEZL_HDR_Z5       0
`define EEZL_TUPLE_STEP   16'h0002

// serial clock: half period in ns, pclk period in ns
`define EEZL_SK_HALF_NS   32
`define EEZL_PCLK_NS      4

`endif

// >>> rtl/eezl_pkg.sv
/*
 * Types shared by the loader and its serial word reader.
 * Assumes nothing of its surroundings.
 */
package eezl_pkg;

    // loader sequence
    typedef enum logic [1:0] {
        LD_IDLE,
        LD_FETCH,
        LD_WAIT,
        LD_NEXT
    } eezl_ld_t;

    // serial read of one word
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_LOW,
        RD_HIGH,
        RD_GAP
    } eezl_rd_t;

endpackage

// >>> rtl/eezl_word_reader.sv
/*
 * Reads one 16-bit word from a serial eeprom: start bit, read opcode,
 * address, one dummy bit, then sixteen data bits, msb first.
 * Assumes sdi has already passed a two-stage synchroniser.
 */
`timescale 1ns/1ns
`include "eezl_map.svh"

module eezl_word_reader #(
    parameter int AW   = 6,                // eeprom address bits
    parameter int HALF = 8                 // pclk cycles per half bit
) (
    input  wire logic          pclk,       // system clock
    input  wire logic          presetn,    // async reset, active low
    input  wire logic          start,      // one-cycle read request
    input  wire logic [AW-1:0] addr,       // word address
    input  wire logic          sdi,        // synchronised eeprom output
    output logic               sk,         // serial clock
    output logic               cs,         // chip select
    output logic               di,         // serial data to eeprom
    output logic [15:0]        rdata,      // word read
    output logic               done        // one-cycle completion
);
    import eezl_pkg::*;

    localparam int TOT = 3 + AW + 1 + 16;
    localparam int BW  = $clog2(TOT + 1);
    localparam int DW  = $clog2(HALF + 1);
    localparam logic [BW-1:0] DATA_FIRST = BW'(3 + AW + 1);
    localparam logic [BW-1:0] LAST       = BW'(TOT - 1);
    localparam logic [DW-1:0] DIV_END    = DW'(HALF - 1);

    eezl_rd_t          st_r;
    logic [DW-1:0]     div_r;
    logic [BW-1:0]     bit_r;
    logic [AW+2:0]     cmd_r;
    logic              div_end;

    assign div_end = (div_r == DIV_END);

    // half-bit timer, restarted on every phase change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
        end else if (st_r == RD_IDLE || div_end) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // bit sequencing; data is sampled late in the high phase so that
    // the two synchroniser cycles have long passed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r  <= RD_IDLE;
            bit_r <= '0;
            cmd_r <= '0;
            sk    <= 1'b0;
            cs    <= 1'b0;
            di    <= 1'b0;
            rdata <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_r)
                RD_IDLE: begin
                    if (start) begin
                        cmd_r <= {3'b110, addr};
                        di    <= 1'b1;
                        cs    <= 1'b1;
                        bit_r <= '0;
                        st_r  <= RD_LOW;
                    end
                end
                RD_LOW: begin
                    if (div_end) begin
                        sk   <= 1'b1;
                        st_r <= RD_HIGH;
                    end
                end
                RD_HIGH: begin
                    if (div_end) begin
                        sk <= 1'b0;
                        if (bit_r >= DATA_FIRST) begin
                            rdata <= {rdata[14:0], sdi};
                        end
                        if (bit_r == LAST) begin
                            cs   <= 1'b0;
                            di   <= 1'b0;
                            st_r <= RD_GAP;
                        end else begin
                            cmd_r <= {cmd_r[AW+1:0], 1'b0};
                            di    <= cmd_r[AW+1];
                            bit_r <= bit_r + 1'b1;
                            st_r  <= RD_LOW;
                        end
                    end
                end
                default: begin
                    // chip select stays low a full half bit between words
                    if (div_end) begin
                        done <= 1'b1;
                        st_r <= RD_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// >>> verification/eezl_checker.sv
/*
 * Pin-level checks of the loader: apb answers and eeprom framing.
 * Assumes a bind onto eezl_loader and one pclk domain.
 */
`timescale 1ns/1ns

module eezl_checker #(
    parameter int AW = 6                 // eeprom address bits
) (
    input wire logic        pclk,        // clock
    input wire logic        presetn,     // reset, active low
    input wire logic        psel,        // apb select
    input wire logic        penable,     // apb access phase
    input wire logic        pready,      // apb ready
    input wire logic        pslverr,     // apb error or retry
    input wire logic [31:0] prdata,      // apb read data
    input wire logic        ee_sk,       // serial clock
    input wire logic        ee_cs,       // chip select
    input wire logic        ee_di        // data to eeprom
);
    // one word frame: 20+AW bits of 16 cycles, small slack either way
    localparam int FR_LO = (20 + AW) * 16 - 8;
    localparam int FR_HI = (20 + AW) * 16 + 8;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // apb: one wait state, one-cycle answer
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata outside answer");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_retry_busy: assert property (pready && ee_cs |-> pslverr)
        else $error("access served during download");
    chk_first_read: assert property ($rose(presetn) |-> ##[1:6] ee_cs)
        else $error("download did not start");
    // eeprom link framing; a short frame would lose data bits
    chk_frame_len: assert property (
        $rose(ee_cs) |-> ##[FR_LO:FR_HI] $fell(ee_cs))
        else $error("frame length wrong");
    chk_sk_half: assert property (
        $rose(ee_sk) && ee_cs |-> ee_sk [*8] ##1 !ee_sk)
        else $error("sk high phase wrong");
    chk_di_steady: assert property (
        ee_cs && $past(ee_cs) && !$fell(ee_sk) |-> $stable(ee_di))
        else $error("di moved off falling sk");
endmodule

bind eezl_loader eezl_checker #(.AW(AW)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .ee_sk(ee_sk), .ee_cs(ee_cs), .ee_di(ee_di)
);

// >>> verification/eezl_eeprom_model.sv
/*
 * Behavioural serial eeprom of 16-bit words, read command only.
 * Assumes the bench fills mem and clears n_rd before each download.
 */
`timescale 1ns/1ns

module eezl_eeprom_model #(
    parameter int AW = 6                 // address bits
) (
    input  wire logic ee_sk,             // serial clock
    input  wire logic ee_cs,             // chip select
    input  wire logic ee_di,             // command and address in
    output logic      ee_do              // data out
);
    logic [15:0]   mem [0:(1<<AW)-1];
    logic [AW-1:0] addr;
    int            n_bit;
    int            n_rd;
    int            n_bad;

    initial begin
        ee_do = 1'b0;
        n_rd = 0;
        n_bad = 0;
    end
    // each select starts a fresh command
    always @(posedge ee_cs) n_bit = 0;
    // released line shows no stale data, so flip it
    always @(negedge ee_cs) begin
        ee_do <= ~ee_do;
        n_rd++;
    end
    // start bit 1 then read opcode 10, then address msb first
    always @(posedge ee_sk) if (ee_cs) begin
        if (n_bit < 3 && ee_di !== (n_bit != 2))
            n_bad++;
        else if (n_bit >= 3 && n_bit < 3 + AW)
            addr = {addr[AW-2:0], ee_di};
        n_bit++;
    end
    // data launched in the low phase after the dummy bit, msb first
    always @(negedge ee_sk) if (ee_cs && n_bit > 3 + AW && n_bit < 20 + AW)
        ee_do <= mem[addr][19+AW-n_bit];
endmodule

// >>> verification/tb_eeprom_zone_config_loader.sv
/*
 * Self-checking bench of the eeprom configuration loader.
 * Assumes the loader, its map header, checker and eeprom model.
 */
`timescale 1ns/1ns
`include "eezl_map.svh"

module tb_eeprom_zone_config_loader;
    localparam logic [11:0] CTRL_A = 12'h000;       // control register
    localparam logic [31:0] PIN_M  = 32'hF7FF_FFFF; // bit 27 echoes pin
    localparam logic [15:0] IMG [8] = '{16'hB51C, 16'hD6A5, 16'h3D3C,
        16'h815A, 16'h0577, 16'h0004, 16'h2211, 16'h4433};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        ee_sk, ee_cs, ee_di, ee_do, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_total, num_checks;

    eezl_loader dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ee_sk(ee_sk), .ee_cs(ee_cs),
        .ee_di(ee_di), .ee_do(ee_do));
    eezl_eeprom_model ee_u (
        .ee_sk(ee_sk), .ee_cs(ee_cs), .ee_di(ee_di), .ee_do(ee_do));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) chk(32'h0, 32'h1, "pready timeout");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // polls until the retry answer stops
    task automatic wait_load();
        int n;
        n = 0;
        do begin
            apb(1'b0, `EEZL_OFF_STATUS, 32'h0000_0000);
            n++;
        end while (er !== 1'b0 && n < 4000);
        chk({31'h0, er}, 32'h0, "download end");
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        ee_u.n_rd = 0;
        presetn <= 1'b1;
    endtask

    // header with zones 1 to 3, out-of-subset zone 2 byte, tuples
    task automatic t_full();
        apb(1'b0, CTRL_A, 32'h0000_0000);
        chk({31'h0, er}, 32'h1, "retry while busy");
        wait_load();
        chk(ee_u.n_rd, 32'h8, "words read");
        chk(rd, 32'h0004_0018, "status after load");
        apb(1'b0, CTRL_A, 32'h0000_0000);
        chk(rd & PIN_M, 32'h1020_5A00, "control");
        apb(1'b0, `EEZL_OFF_CIS, 32'h0000_0000);
        chk(rd, 32'h4433_2211, "tuple dword");
        apb(1'b0, 12'h0F0, 32'h0000_0000);
        chk({31'h0, er}, 32'h1, "unmapped");
    endtask

    task automatic t_pm();
        apb(1'b1, `EEZL_OFF_PM_SEL, 32'h0000_0005);
        apb(1'b0, `EEZL_OFF_PM_DATA, 32'h0000_0000);
        chk(rd, 32'h0000_02A5, "pm entry 5");
        apb(1'b1, `EEZL_OFF_PM_SEL, 32'h0000_000F);
        apb(1'b0, `EEZL_OFF_PM_DATA, 32'h0000_0000);
        chk(rd, 32'h0000_013C, "pm entry 15");
    endtask

    // software reload of an image with zone 3 only
    task automatic t_reload();
        ee_u.mem[0] = 16'hB504;
        ee_u.mem[1] = 16'h0002;
        ee_u.mem[2] = 16'hBEEF;
        ee_u.n_rd = 0;
        apb(1'b1, CTRL_A, 32'h2020_5A00);
        apb(1'b0, CTRL_A, 32'h0000_0000);
        chk({31'h0, er}, 32'h1, "retry on reload");
        wait_load();
        chk(ee_u.n_rd, 32'h3, "words on reload");
        apb(1'b0, `EEZL_OFF_CIS, 32'h0000_0000);
        chk({16'h0, rd[15:0]}, 32'h0000_BEEF, "tuple reload");
        apb(1'b1, CTRL_A, 32'h0000_0000);
        apb(1'b0, CTRL_A, 32'h0000_0000);
        chk(rd & PIN_M, 32'h1000_0000, "valid bit kept");
        apb(1'b0, `EEZL_OFF_CIS, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "hardwired cis");
    endtask

    // bad signature, then pins driven by software
    task automatic t_bad();
        ee_u.mem[0] = 16'hA51C;
        do_reset();
        wait_load();
        chk(ee_u.n_rd, 32'h1, "header only");
        apb(1'b0, CTRL_A, 32'h0000_0000);
        chk(rd & PIN_M, 32'h0000_0000, "control untouched");
        apb(1'b1, CTRL_A, 32'h0500_0000);
        repeat (3) @(posedge pclk);
        chk({29'h0, ee_sk, ee_cs, ee_di}, 32'h5, "pin drive");
    endtask

    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_total = 0;
        num_checks = 0;
        for (int i = 0; i < 64; i++)
            ee_u.mem[i] = (i < 8) ? IMG[i] : 16'hFFFF;
        do_reset();
        t_full();
        t_pm();
        t_reload();
        t_bad();
        chk(ee_u.n_bad, 32'h0, "read command bits");
        stop_test();
    end

    // hang guard, far beyond three downloads
    initial begin
        #200000;
        $display("ERROR %0t watchdog expired", $time);
        err_total++;
        stop_test();
    end
endmodule
